// ==== tcc_capture_compare.sv ====
/*
 * Input capture and two output compare channels beside a 16-bit
 * counter. CPU writes 16-bit registers as bytes through one shared
 * high-byte latch, also used for capture reads. Assumes counter, prescaler and mode logic live
 * outside and deliver counter_value, timer_tick, at_top and at_bottom,
 * all synchronous to sys_clk.
 */
`timescale 1ns/10ps
module tcc_capture_compare #(
   parameter int CW = tcc_pkg::CNT_W,
   parameter int BW = tcc_pkg::BYTE_W,
   parameter int NCH = tcc_pkg::NUM_CH
) (
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          timer_tick,
   input  wire logic [CW-1:0] counter_value,
   input  wire logic          counter_write,
   input  wire logic          at_top,
   input  wire logic          at_bottom,
   input  wire logic [3:0]    waveform_mode_bits,
   input  wire logic          capture_pin,
   input  wire logic          comparator_output,
   input  wire logic          comparator_capture_select,
   input  wire logic          noise_filter_enable,
   input  wire logic          edge_select,
   input  wire logic          capture_irq_enable,
   input  wire logic          capture_flag_write_one,
   input  wire logic          capture_irq_ack,
   input  wire logic          cpu_wr,
   input  wire logic          cpu_rd,
   input  wire logic [2:0]    cpu_addr,
   input  wire logic [BW-1:0] cpu_wr_data,
   output logic      [BW-1:0] cpu_rd_data,
   input  wire logic [NCH-1:0] compare_irq_enable,
   input  wire logic [NCH-1:0] compare_flag_write_one,
   input  wire logic [NCH-1:0] compare_irq_ack,
   input  wire logic [NCH-1:0] force_compare_strobe,
   input  wire logic [2*NCH-1:0] output_action_bits,
   output logic      [CW-1:0] capture_register,
   output logic               capture_flag,
   output logic               capture_irq,
   output logic      [CW-1:0] compare_a_value,
   output logic      [NCH-1:0] compare_match,
   output logic      [NCH-1:0] compare_flag,
   output logic      [NCH-1:0] compare_irq,
   output logic      [NCH-1:0] compare_output_state
);
   // =========================================================
   // Mode decode
   wire pwm_mode = tcc_pkg::PWM_MODES[waveform_mode_bits];
   wire cap_top_mode = tcc_pkg::CAP_TOP_MODES[waveform_mode_bits];
   wire upd_at_top = tcc_pkg::UPD_AT_TOP_MODES[waveform_mode_bits];
   // Buffer transfer point for double-buffered compare values
   wire buf_load = timer_tick &&
                   (upd_at_top ? at_top : at_bottom);

   // =========================================================
   // Capture trigger path
   // Source mux ahead of the filter: a swap can look like an edge
   wire cap_src = comparator_capture_select ? comparator_output
                                            : capture_pin;
   logic cap_filt;
   logic cap_prev;

   tcc_noise_filter #(
      .LEN           (tcc_pkg::FILTER_LEN)
   ) u_filter (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .filter_enable (noise_filter_enable),
      .raw_in        (cap_src),
      .filtered_out  (cap_filt)
   );

   // Edge detector qualified by edge select and mode
   wire rise = cap_filt && !cap_prev;
   wire fall = !cap_filt && cap_prev;
   wire cap_edge = edge_select ? rise : fall;
   wire capture_now = cap_edge && !cap_top_mode;

   // Previous filtered level
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_prev <= 1'b0;
      end else begin
         cap_prev <= cap_filt;
      end
   end

   // =========================================================
   // CPU byte-access decode
   wire wr_cap_low = cpu_wr && cpu_addr == tcc_pkg::ADDR_CAP_LOW;
   wire wr_cap_ok = wr_cap_low && cap_top_mode;
   wire rd_cap_low = cpu_rd && cpu_addr == tcc_pkg::ADDR_CAP_LOW;
   wire rd_cap_high = cpu_rd && cpu_addr == tcc_pkg::ADDR_CAP_HIGH;
   logic [NCH-1:0] wr_cmp_low;
   logic [NCH-1:0] wr_high;
   logic [BW-1:0]  temp_byte;
   logic [CW-1:0]  cmp_view [NCH];

   // Shared high byte: every high write lands here
   wire any_high_wr = |wr_high ||
                      (cpu_wr && cpu_addr == tcc_pkg::ADDR_CAP_HIGH);

   // Temp latch: high write, or low capture read snapshot
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         temp_byte <= '0;
      end else if (any_high_wr) begin
         temp_byte <= cpu_wr_data;
      end else if (rd_cap_low) begin
         temp_byte <= capture_register[CW-1:BW];
      end
   end

   // =========================================================
   // Capture register and flag
   // Overwritten on every capture, read or not
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         capture_register <= '0;
      end else if (capture_now) begin
         capture_register <= counter_value;
      end else if (wr_cap_ok) begin
         capture_register <= {temp_byte, cpu_wr_data};
      end
   end

   // Set beats clear when both land together
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         capture_flag <= 1'b0;
      end else if (capture_now) begin
         capture_flag <= 1'b1;
      end else if (capture_flag_write_one || capture_irq_ack) begin
         capture_flag <= 1'b0;
      end
   end

   assign capture_irq = capture_flag && capture_irq_enable;

   // =========================================================
   // Match blocking after a counter write
   // Writing the counter thus skips any match on the next timer tick
   logic block_pending;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         block_pending <= 1'b0;
      end else if (counter_write) begin
         block_pending <= 1'b1;
      end else if (timer_tick) begin
         block_pending <= 1'b0;
      end
   end

   // =========================================================
   // Compare channels
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         logic [CW-1:0] cmp_reg;
         logic [CW-1:0] cmp_buf;
         wire [2:0] lo_addr = 3'(tcc_pkg::ADDR_CMP_LOW +
                                 tcc_pkg::ADDR_CH_STEP * ch);
         wire [2:0] hi_addr = 3'(tcc_pkg::ADDR_CMP_HIGH +
                                 tcc_pkg::ADDR_CH_STEP * ch);
         wire [1:0] action = output_action_bits[2*ch +: 2];
         wire eq = counter_value == cmp_reg;
         wire hit = timer_tick && eq && !block_pending;
         wire forced = force_compare_strobe[ch] && !pwm_mode;
         wire act_now = (hit || forced) && !pwm_mode;

         assign wr_cmp_low[ch] = cpu_wr && cpu_addr == lo_addr;
         assign wr_high[ch] = cpu_wr && cpu_addr == hi_addr;
         // CPU sees the buffer in PWM modes, the live value otherwise
         assign cmp_view[ch] = pwm_mode ? cmp_buf : cmp_reg;
         assign compare_match[ch] = hit;

         // Buffer catches every low-byte commit, in any mode
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cmp_buf <= '0;
            end else if (wr_cmp_low[ch]) begin
               cmp_buf <= {temp_byte, cpu_wr_data};
            end
         end

         // Live compare value: direct write or buffer transfer
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cmp_reg <= '0;
            end else if (wr_cmp_low[ch] && !pwm_mode) begin
               cmp_reg <= {temp_byte, cpu_wr_data};
            end else if (pwm_mode && buf_load) begin
               cmp_reg <= cmp_buf;
            end
         end

         // Flag: match sets, ack or write-one clears, set wins
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               compare_flag[ch] <= 1'b0;
            end else if (hit) begin
               compare_flag[ch] <= 1'b1;
            end else if (compare_flag_write_one[ch] ||
                         compare_irq_ack[ch]) begin
               compare_flag[ch] <= 1'b0;
            end
         end

         // Output state kept across mode changes; action read live
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               compare_output_state[ch] <= 1'b0;
            end else if (act_now) begin
               case (action)
                  tcc_pkg::ACT_TOGGLE:
                     compare_output_state[ch] <= !compare_output_state[ch];
                  tcc_pkg::ACT_CLEAR:
                     compare_output_state[ch] <= 1'b0;
                  tcc_pkg::ACT_SET:
                     compare_output_state[ch] <= 1'b1;
                  default:
                     compare_output_state[ch] <= compare_output_state[ch];
               endcase
            end
         end

         assign compare_irq[ch] = compare_flag[ch] &&
                                  compare_irq_enable[ch];
      end
   endgenerate

   // Channel A drives the counter TOP in its TOP modes
   assign compare_a_value = g_ch[0].cmp_reg;

   // =========================================================
   // Read data mux, registered on the read strobe
   logic [BW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (rd_cap_low) begin
         rd_mux = capture_register[BW-1:0];
      end else if (rd_cap_high) begin
         rd_mux = temp_byte;
      end
      for (int i = 0; i < NCH; i++) begin
         if (cpu_addr == 3'(tcc_pkg::ADDR_CMP_LOW +
                            tcc_pkg::ADDR_CH_STEP * i)) begin
            rd_mux = cmp_view[i][BW-1:0];
         end else if (cpu_addr == 3'(tcc_pkg::ADDR_CMP_HIGH +
                                     tcc_pkg::ADDR_CH_STEP * i)) begin
            rd_mux = cmp_view[i][CW-1:BW];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_rd_data <= '0;
      end else if (cpu_rd) begin
         cpu_rd_data <= rd_mux;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_capture_copy : assert property (
      capture_now |=> capture_register == $past(counter_value))
      else $error("capture did not copy the counter value");
   a_capture_flag_set : assert property (
      $rose(capture_flag) |-> $past(capture_now))
      else $error("capture flag rose without a capture");
   a_capture_flag_clear : assert property (
      (capture_irq_ack && !capture_now) |=> !capture_flag)
      else $error("capture flag survived service");
   a_temp_snapshot : assert property (
      (rd_cap_low && !any_high_wr) ##1 (!rd_cap_low && !any_high_wr)
      ##1 rd_cap_high |=> cpu_rd_data == $past(capture_register[CW-1:BW], 3))
      else $error("capture high byte not from the latch");
   a_cap_write_gate : assert property (
      (wr_cap_low && !cap_top_mode && !capture_now) |=>
         $stable(capture_register))
      else $error("capture register written outside its modes");
   a_cmp_flag_cause : assert property (
      $rose(compare_flag[0]) |->
         $past(timer_tick && counter_value == g_ch[0].cmp_reg))
      else $error("compare flag rose without a match");
   a_match_blocked : assert property (
      counter_write ##1 (timer_tick && !counter_write) |->
         compare_match == '0)
      else $error("match not blocked after counter write");
   a_force_no_flag : assert property (
      (force_compare_strobe[1] && !compare_match[1] &&
       !compare_flag[1]) |=> !compare_flag[1])
      else $error("force set the compare flag");

   c_capture : cover property (capture_now ##1 capture_flag);
   c_forced : cover property (force_compare_strobe[0] && !pwm_mode);
   c_blocked : cover property (counter_write ##1 timer_tick);
endmodule

// ==== tcc_pkg.sv ====
/*
 * Shared constants for the timer capture/compare block: byte-port
 * addresses, waveform-mode groups, output actions and filter length.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcc_pkg;
   // =========================================================
   // Widths, channel count and filter length
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam int NUM_CH = 2;
   localparam int FILTER_LEN = 4;

   // =========================================================
   // Byte-port addresses (8-bit CPU view of 16-bit registers)
   localparam logic [2:0] ADDR_CAP_LOW = 3'h0;
   localparam logic [2:0] ADDR_CAP_HIGH = 3'h1;
   localparam logic [2:0] ADDR_CMP_LOW = 3'h2;  // Channel n at +2n
   localparam logic [2:0] ADDR_CMP_HIGH = 3'h3; // Channel n at +2n
   localparam logic [2:0] ADDR_CH_STEP = 3'h2;

   // =========================================================
   // Waveform-mode groups, one bit per mode code 0..15
   localparam logic [15:0] PWM_MODES = 16'hCFEE;
   localparam logic [15:0] CAP_TOP_MODES = 16'h5500;
   localparam logic [15:0] UPD_AT_TOP_MODES = 16'h0C0E;

   // =========================================================
   // Output actions on a non-PWM match
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Filter states
   typedef enum logic [1:0] {
      TCC_FLT_LOW  = 2'b00,
      TCC_FLT_HIGH = 2'b01
   } tcc_flt_t;
endpackage

// ==== tcc_noise_filter.sv ====
/*
 * Capture noise filter: the output follows the input only after
 * FILTER_LEN equal consecutive samples; bypassed when disabled.
 * Assumes the input is already synchronous to sys_clk.
 */
`timescale 1ns/10ps
module tcc_noise_filter #(
   parameter int LEN = tcc_pkg::FILTER_LEN
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic filter_enable,
   input  wire logic raw_in,
   output logic      filtered_out
);
   // =========================================================
   // Sample history and filter state
   logic [LEN-1:0]     hist;
   tcc_pkg::tcc_flt_t  state;
   tcc_pkg::tcc_flt_t  next_state;
   wire                all_high = &hist;
   wire                all_low = ~|hist;

   // Output only moves on unanimous history
   always_comb begin
      case (state)
         tcc_pkg::TCC_FLT_LOW:
            next_state = all_high ? tcc_pkg::TCC_FLT_HIGH
                                  : tcc_pkg::TCC_FLT_LOW;
         tcc_pkg::TCC_FLT_HIGH:
            next_state = all_low ? tcc_pkg::TCC_FLT_LOW
                                 : tcc_pkg::TCC_FLT_HIGH;
         default:
            next_state = tcc_pkg::TCC_FLT_LOW;
      endcase
   end

   // Runs on sys_clk so the prescaler never stretches it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hist  <= '0;
         state <= tcc_pkg::TCC_FLT_LOW;
      end else begin
         hist  <= {hist[LEN-2:0], raw_in};
         state <= next_state;
      end
   end

   // Disabled: one register stage, same as the edge path without filter
   assign filtered_out = filter_enable ? (state == tcc_pkg::TCC_FLT_HIGH)
                                       : hist[0];

   // =========================================================
   // Assertions
   a_filter_unanimous : assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (filter_enable && $changed(state)) |->
         ($past(hist) == '0 || $past(hist) == '1))
      else $error("filter output moved without four equal samples");
endmodule

// ==== tcc_event_src.sv ====
/*
 * Event source model standing in for the capture pin driver and the
 * analog comparator output. Assumes its tasks are called just after a
 * rising edge of sys_clk, so every level change is synchronous.
 */
`timescale 1ns/10ps
module tcc_event_src (
   input  wire logic sys_clk,
   output logic      capture_pin,
   output logic      comparator_output
);
   // =========================================================
   // Idle levels; both sources are push-pull, never released
   initial begin
      capture_pin = 1'b0;
      comparator_output = 1'b0;
   end

   // Level changes are held until the next call
   task automatic drive_pin(input logic v);
      capture_pin = v;
   endtask

   task automatic drive_cmp(input logic v);
      comparator_output = v;
   endtask

   // Short pulse that a working filter must swallow
   task automatic glitch_pin(input int n);
      capture_pin = ~capture_pin;
      repeat (n) @(posedge sys_clk);
      #1;
      capture_pin = ~capture_pin;
   endtask
endmodule

// ==== tb_top.sv ====
/*
 * Self-checking bench for the capture/compare block: capture timing,
 * filter, source select, byte access, compare, force and buffering.
 * Assumes the event source model drives the two capture sources.
 */
`timescale 1ns/10ps
module tb_top;
   localparam int TMO = 3000; // Whole run needs well under 1000 cycles
   logic sys_clk, sys_rst, timer_tick, counter_write, at_top, at_bottom;
   logic comparator_capture_select, noise_filter_enable, edge_select;
   logic capture_irq_enable, capture_flag_write_one, capture_irq_ack;
   logic cpu_wr, cpu_rd, capture_flag, capture_irq;
   logic [15:0] counter_value, capture_register, compare_a_value;
   logic [3:0]  waveform_mode_bits, output_action_bits;
   logic [2:0]  cpu_addr;
   logic [7:0]  cpu_wr_data, cpu_rd_data, rd;
   logic [1:0]  compare_irq_enable, compare_flag_write_one, compare_irq_ack;
   logic [1:0]  force_compare_strobe, compare_match, compare_flag;
   logic [1:0]  compare_irq, compare_output_state;
   wire         capture_pin, comparator_output;
   int          bad_count, n_checks, cyc, n;

   // =========================================================
   // Design and event source
   tcc_event_src i_tcc_event_src (.sys_clk(sys_clk),
      .capture_pin(capture_pin), .comparator_output(comparator_output));

   tcc_capture_compare i_tcc_capture_compare (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .timer_tick(timer_tick),
      .counter_value(counter_value), .counter_write(counter_write),
      .at_top(at_top), .at_bottom(at_bottom),
      .waveform_mode_bits(waveform_mode_bits), .capture_pin(capture_pin),
      .comparator_output(comparator_output),
      .comparator_capture_select(comparator_capture_select),
      .noise_filter_enable(noise_filter_enable), .edge_select(edge_select),
      .capture_irq_enable(capture_irq_enable),
      .capture_flag_write_one(capture_flag_write_one),
      .capture_irq_ack(capture_irq_ack), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_addr(cpu_addr), .cpu_wr_data(cpu_wr_data),
      .cpu_rd_data(cpu_rd_data), .compare_irq_enable(compare_irq_enable),
      .compare_flag_write_one(compare_flag_write_one),
      .compare_irq_ack(compare_irq_ack),
      .force_compare_strobe(force_compare_strobe),
      .output_action_bits(output_action_bits),
      .capture_register(capture_register), .capture_flag(capture_flag),
      .capture_irq(capture_irq), .compare_a_value(compare_a_value),
      .compare_match(compare_match), .compare_flag(compare_flag),
      .compare_irq(compare_irq), .compare_output_state(compare_output_state));

   // =========================================================
   // Clock, timeout and shared tasks
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // A hang is cut short here and counted as a mismatch
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == TMO) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask

   // Strobe is dropped for a cycle so back-to-back calls stay clean
   task automatic cpu_write(input logic [2:0] a, input logic [7:0] d);
      cpu_addr = a;
      cpu_wr_data = d;
      cpu_wr = 1'b1;
      step(1);
      cpu_wr = 1'b0;
      step(1);
   endtask

   task automatic cpu_read(input logic [2:0] a);
      cpu_addr = a;
      cpu_rd = 1'b1;
      step(1);
      cpu_rd = 1'b0;
      rd = cpu_rd_data;
      step(1);
   endtask

   // Counts edges until the capture flag shows, bounded
   task automatic cap_wait();
      n = 0;
      while (capture_flag !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
   endtask

   task automatic clr_cap();
      capture_flag_write_one = 1'b1;
      step(1);
      capture_flag_write_one = 1'b0;
      step(1);
   endtask

   // =========================================================
   // Scenarios
   task automatic sc_capture();
      counter_value = 16'h1234;
      i_tcc_event_src.drive_pin(1'b1);
      cap_wait();
      chk_word(16'(n), 16'h0002);
      chk_word(capture_register, 16'h1234);
      chk_bit(capture_irq, 1'b1);
      clr_cap();
      chk_bit(capture_flag, 1'b0);
      counter_value = 16'h2222;
      i_tcc_event_src.drive_pin(1'b0);
      step(6);
      chk_bit(capture_flag, 1'b0);
      edge_select = 1'b0;
      i_tcc_event_src.drive_pin(1'b1);
      step(6);
      counter_value = 16'h3456;
      capture_irq_enable = 1'b0;
      i_tcc_event_src.drive_pin(1'b0);
      cap_wait();
      chk_word(capture_register, 16'h3456);
      chk_bit(capture_irq, 1'b0);
      capture_irq_ack = 1'b1;
      step(1);
      capture_irq_ack = 1'b0;
      step(1);
      chk_bit(capture_flag, 1'b0);
   endtask

   task automatic sc_filter();
      step(2); // Filter state lags the pin; switching it in early looks an edge
      noise_filter_enable = 1'b1;
      edge_select = 1'b1;
      counter_value = 16'h0ABC;
      i_tcc_event_src.glitch_pin(3);
      step(10);
      chk_bit(capture_flag, 1'b0);
      i_tcc_event_src.drive_pin(1'b1);
      cap_wait();
      chk_word(16'(n), 16'(2 + tcc_pkg::FILTER_LEN));
      chk_word(capture_register, 16'h0ABC);
      noise_filter_enable = 1'b0;
      clr_cap();
   endtask

   // Source change may capture on its own, so the flag is cleared after
   task automatic sc_source();
      comparator_capture_select = 1'b1;
      step(6);
      clr_cap();
      i_tcc_event_src.drive_pin(1'b0);
      step(4);
      i_tcc_event_src.drive_pin(1'b1);
      step(6);
      chk_bit(capture_flag, 1'b0);
      counter_value = 16'h0C0C;
      i_tcc_event_src.drive_cmp(1'b1);
      cap_wait();
      chk_word(capture_register, 16'h0C0C);
      comparator_capture_select = 1'b0;
      step(6);
      clr_cap();
   endtask

   // High byte must come from the latch, not from a newer capture
   task automatic sc_cap_read();
      cpu_read(3'h0);
      chk_word({8'h00, rd}, 16'h000C);
      edge_select = 1'b0;
      counter_value = 16'h7788;
      i_tcc_event_src.drive_pin(1'b0);
      cap_wait();
      cpu_read(3'h1);
      chk_word({8'h00, rd}, 16'h000C);
      cpu_read(3'h0);
      cpu_read(3'h1);
      chk_word({8'h00, rd}, 16'h0077);
      clr_cap();
   endtask

   task automatic sc_cap_top();
      waveform_mode_bits = 4'hC;
      edge_select = 1'b1;
      i_tcc_event_src.drive_pin(1'b1);
      step(8);
      i_tcc_event_src.drive_pin(1'b0);
      step(8);
      chk_bit(capture_flag, 1'b0);
      cpu_write(3'h1, 8'hAB);
      cpu_write(3'h0, 8'hCD);
      chk_word(capture_register, 16'hABCD);
      waveform_mode_bits = 4'h0;
      cpu_write(3'h1, 8'h11);
      cpu_write(3'h0, 8'h22);
      chk_word(capture_register, 16'hABCD);
   endtask

   task automatic sc_compare();
      logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
      logic       ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      cpu_write(3'h3, 8'h5A);
      cpu_write(3'h2, 8'h40);
      chk_word(compare_a_value, 16'h5A40);
      cpu_read(3'h0);
      cpu_read(3'h3);
      chk_word({8'h00, rd}, 16'h005A);
      compare_irq_enable = 2'b01;
      counter_value = 16'h5A40;
      for (int i = 0; i < 5; i++) begin
         output_action_bits = {2'h0, acts[i]};
         timer_tick = 1'b1;
         #1;
         chk_bit(compare_match[0], 1'b1);
         step(1);
         timer_tick = 1'b0;
         chk_bit(compare_flag[0], 1'b1);
         chk_bit(compare_irq[0], 1'b1);
         chk_bit(compare_output_state[0], ex[i]);
         compare_irq_ack = 2'b01;
         step(1);
         compare_irq_ack = 2'b00;
         step(1);
         chk_bit(compare_flag[0], 1'b0);
      end
   endtask

   task automatic sc_block();
      counter_write = 1'b1;
      step(1);
      counter_write = 1'b0;
      timer_tick = 1'b1;
      #1;
      chk_bit(compare_match[0], 1'b0);
      step(1);
      chk_bit(compare_flag[0], 1'b0);
      step(1);
      timer_tick = 1'b0;
      chk_bit(compare_flag[0], 1'b1);
      compare_flag_write_one = 2'b01;
      step(1);
      compare_flag_write_one = 2'b00;
      step(1);
      chk_bit(compare_flag[0], 1'b0);
   endtask

   task automatic sc_force_buffer();
      cpu_write(3'h5, 8'h5A);
      cpu_write(3'h4, 8'h40);
      compare_irq_enable = 2'b10;
      timer_tick = 1'b1;
      step(1);
      timer_tick = 1'b0;
      chk_word({12'h000, compare_flag, compare_irq}, 16'h000E);
      compare_irq_ack = 2'b10;
      compare_flag_write_one = 2'b01;
      step(1);
      compare_irq_ack = 2'b00;
      compare_flag_write_one = 2'b00;
      chk_word({14'h0000, compare_flag}, 16'h0000);
      output_action_bits = 4'h7;
      force_compare_strobe = 2'b11;
      step(1);
      force_compare_strobe = 2'b00;
      chk_bit(compare_output_state[1], 1'b1);
      chk_bit(compare_output_state[0], 1'b1);
      chk_bit(compare_flag[1], 1'b0);
      waveform_mode_bits = 4'h5;
      force_compare_strobe = 2'b10;
      step(1);
      force_compare_strobe = 2'b00;
      step(1);
      chk_bit(compare_output_state[1], 1'b1);
      cpu_write(3'h3, 8'h01);
      cpu_write(3'h2, 8'h02);
      chk_word(compare_a_value, 16'h5A40);
      cpu_read(3'h2);
      chk_word({8'h00, rd}, 16'h0002);
      buf_edge(1'b0, 16'h5A40);
      buf_edge(1'b1, 16'h0102);
      waveform_mode_bits = 4'h1;
      cpu_write(3'h3, 8'h03);
      cpu_write(3'h2, 8'h04);
      buf_edge(1'b1, 16'h0102);
      buf_edge(1'b0, 16'h0304);
   endtask

   // One cycle at BOTTOM (bot=1) or TOP (bot=0) with a timer tick
   task automatic buf_edge(input logic bot, input logic [15:0] exp);
      at_bottom = bot;
      at_top = ~bot;
      timer_tick = 1'b1;
      step(1);
      at_bottom = 1'b0;
      at_top = 1'b0;
      timer_tick = 1'b0;
      step(1);
      chk_word(compare_a_value, exp);
   endtask

   // =========================================================
   // Verdict and main sequence
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      {timer_tick, counter_write, at_top, at_bottom, cpu_wr, cpu_rd} = 6'h00;
      {comparator_capture_select, noise_filter_enable} = 2'h0;
      {capture_flag_write_one, capture_irq_ack} = 2'h0;
      edge_select = 1'b1;
      capture_irq_enable = 1'b1;
      counter_value = 16'h0000;
      waveform_mode_bits = 4'h0;
      output_action_bits = 4'h0;
      cpu_addr = 3'h0;
      cpu_wr_data = 8'h00;
      {compare_irq_enable, compare_flag_write_one} = 4'h0;
      {compare_irq_ack, force_compare_strobe} = 4'h0;
      sys_rst = 1'b1;
      step(8);
      sys_rst = 1'b0;
      chk_word({14'h0000, compare_output_state}, 16'h0000);
      sc_capture();
      sc_filter();
      sc_source();
      sc_cap_read();
      sc_cap_top();
      sc_compare();
      sc_block();
      sc_force_buffer();
      end_of_test();
   end
endmodule
